/* File: bench/basic_timer_bench.sv */
// self-checking bench for the APB 8-bit timer
`timescale 1ns/1ns
module basic_timer_bench;
   reg clock;
   reg rst;
   reg psel;
   reg penable;
   reg pwrite;
   reg [7:0] paddr;
   reg [31:0] pwdata;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire irq;
   wire updateEvent;
   reg useMin;
   wire [31:0] prdataMin;
   wire preadyMin;
   wire pslverrMin;
   wire irqMin;
   integer mismatches;
   integer checkCount;
   integer i;
   reg [31:0] rd;
   reg err;

   basic_timer #(.SYNCED(1), .COMPACT_LAYOUT(0), .ADDR_W(8), .DIV_W(7)) dut_u (
      .clock(clock), .rst(rst), .psel(psel & ~useMin), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq),
      .updateEvent(updateEvent));

   // minimal variant in compact layout, selected by useMin
   basic_timer #(.SYNCED(0), .COMPACT_LAYOUT(1), .ADDR_W(8), .DIV_W(7))
      dutMin_u (
      .clock(clock), .rst(rst), .psel(psel & useMin), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdataMin),
      .pready(preadyMin), .pslverr(pslverrMin), .irq(irqMin),
      .updateEvent());

   // ************************************************
   // bus and compare tasks
   // ************************************************
   task compare(input [8*12:1] nm, input [31:0] e, input [31:0] got);
      begin
         checkCount = checkCount + 1;
         if (got !== e) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0s expected %h seen %h", nm, e, got);
         end
      end
   endtask

   // one APB transfer; holds the request until pready at a rising edge
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clock);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         n = 0;
         @(posedge clock);
         while ((useMin ? preadyMin : pready) !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge clock);
         end
         if (n == 20) mismatches = mismatches + 1;
         rd = useMin ? prdataMin : prdata;
         err = useMin ? pslverrMin : pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdc(input [8*12:1] nm, input [7:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         compare(nm, e, rd);
      end
   endtask

   task wrRd(input [8*12:1] nm, input [7:0] a, input [31:0] d,
             input [31:0] e);
      begin
         wr(a, d);
         rdc(nm, a, e);
      end
   endtask

   // irq is sampled mid-cycle, well after the edge has settled
   task irqIs(input e);
      begin
         @(negedge clock);
         compare("irq", {31'h0, e}, {31'h0, irq});
      end
   endtask

   task closeOut;
      begin
         $display("checks %0d mismatches %0d", checkCount, mismatches);
         if (mismatches == 0 && checkCount > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // free-running 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // watchdog cuts a hung run short
   initial begin
      #400000;
      mismatches = mismatches + 1;
      closeOut;
   end

   // ************************************************
   // test sequence
   // ************************************************
   initial begin
      mismatches = 0;
      checkCount = 0;
      useMin = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 9; i = i + 1)
         rdc("reset", {i[5:0], 2'b00}, (i == 8) ? 32'hff : 32'h0);
      irqIs(1'b0);
      $display("test reset values done");
      wrRd("sync out", 8'h04, 32'hffffffff, 32'h70);
      wrRd("sync in", 8'h08, 32'hffffffff, 32'hf7);
      wrRd("irq enable", 8'h0c, 32'hffffffff, 32'h41);
      wr(8'h0c, 32'h0);
      wrRd("divider", 8'h1c, 32'hffffffff, 32'h07);
      wrRd("reload", 8'h20, 32'h5a, 32'h5a);
      wrRd("count", 8'h18, 32'ha5, 32'ha5);
      wrRd("request", 8'h14, 32'h0, 32'h0);
      rdc("flags", 8'h10, 32'h0);
      apb(1'b0, 8'h24, 32'h0);
      compare("slverr", 32'h1, {31'h0, err});
      compare("unmapped", 32'h0, rd);
      $display("test access kinds done");
      wr(8'h14, 32'h40);
      rdc("flags", 8'h10, 32'h40);
      irqIs(1'b0);
      rdc("request", 8'h14, 32'h0);
      wr(8'h10, 32'h40);
      wr(8'h0c, 32'h40);
      wr(8'h14, 32'h40);
      irqIs(1'b1);
      wr(8'h10, 32'h40);
      irqIs(1'b0);
      wr(8'h0c, 32'h0);
      $display("test trigger done");
      wr(8'h1c, 32'h3);
      wr(8'h20, 32'hff);
      wr(8'h00, 32'h01);
      wr(8'h14, 32'h01);
      @(negedge clock);
      compare("update pulse", 32'h1, {31'h0, updateEvent});
      repeat (10) @(posedge clock);
      rdc("count", 8'h18, 32'h01);
      repeat (18) @(posedge clock);
      rdc("count", 8'h18, 32'h04);
      rdc("flags", 8'h10, 32'h01);
      wrRd("flags", 8'h10, 32'h01, 32'h0);
      $display("test prescaler done");
      wr(8'h00, 32'h0);
      wr(8'h1c, 32'h0);
      wr(8'h14, 32'h01);
      wr(8'h20, 32'h03);
      wr(8'h10, 32'h01);
      wr(8'h0c, 32'h01);
      wr(8'h00, 32'h09);
      repeat (10) @(posedge clock);
      rdc("control", 8'h00, 32'h08);
      rdc("count", 8'h18, 32'h0);
      rdc("flags", 8'h10, 32'h01);
      irqIs(1'b1);
      wr(8'h10, 32'h01);
      wr(8'h0c, 32'h0);
      $display("test one shot done");
      wr(8'h1c, 32'h2);
      wr(8'h20, 32'hff);
      wr(8'h00, 32'h02);
      wr(8'h14, 32'h01);
      @(negedge clock);
      compare("no pulse", 32'h0, {31'h0, updateEvent});
      rdc("flags", 8'h10, 32'h0);
      rdc("count", 8'h18, 32'h0);
      wr(8'h00, 32'h03);
      repeat (4) @(posedge clock);
      apb(1'b0, 8'h18, 32'h0);
      compare("fast count", 32'h5, rd);
      wr(8'h00, 32'h0);
      $display("test update disable done");
      useMin <= 1'b1;
      wrRd("min irq en", 8'h04, 32'hffffffff, 32'h01);
      wr(8'h0c, 32'h41);
      rdc("min flags", 8'h08, 32'h01);
      rdc("min reload", 8'h18, 32'hff);
      @(negedge clock);
      compare("min irq", 32'h1, {31'h0, irqMin});
      apb(1'b0, 8'h38, 32'h0);
      compare("min slverr", 32'h1, {31'h0, err});
      useMin <= 1'b0;
      $display("test minimal variant done");
      closeOut;
   end
endmodule // basic_timer_bench

/* File: bench/basic_timer_properties.sv */
// port assertions for the APB 8-bit timer
`timescale 1ns/1ns
module basic_timer_properties #(
   parameter SYNCED = 1,
   parameter COMPACT_LAYOUT = 0,
   parameter ADDR_W = 8
) (
   input wire clock,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire irq,
   input wire updateEvent
);
   // compact minimal layout moves irq enable and later two words down
   localparam [7:0] SHIFT = (SYNCED == 0 && COMPACT_LAYOUT != 0) ?
      8'h08 : 8'h00;
   localparam [7:0] ADDR_IE = 8'h0c - SHIFT;
   localparam [7:0] ADDR_REQ = 8'h14 - SHIFT;
   localparam [7:0] ADDR_LAST = 8'h20 - SHIFT;
   localparam [7:0] IE_MASK = (SYNCED != 0) ? 8'h41 : 8'h01;
   wire acc = psel && penable && pready;
   wire wr = acc && pwrite;
   wire ugWr = wr && paddr == ADDR_REQ && pwdata[0];
   wire tgWr = wr && paddr == ADDR_REQ && pwdata[6] && SYNCED != 0;
   // gapped minimal layout leaves the two sync words unmapped
   wire gapHole = SYNCED == 0 && COMPACT_LAYOUT == 0 &&
      (paddr == 8'h04 || paddr == 8'h08);
   reg [7:0] ctrlCopy_reg;
   reg [7:0] ieCopy_reg;

   // mirror control and irq enable as software writes them
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrlCopy_reg <= 8'h00;
         ieCopy_reg <= 8'h00;
      end else if (wr) begin
         if (paddr == 8'h00) ctrlCopy_reg <= pwdata[7:0];
         if (paddr == ADDR_IE) ieCopy_reg <= pwdata[7:0] & IE_MASK;
      end
   end

   // ************************************************
   // properties
   // ************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   chk_read_upper_zero: assert property (
      acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
   chk_request_reads_zero: assert property (
      acc && !pwrite && paddr == ADDR_REQ |-> prdata == 32'h0)
      else $error("request read not zero");
   chk_sw_update_event: assert property (
      ugWr && !ctrlCopy_reg[1] |=> updateEvent) else $error("no update");
   chk_disable_blocks: assert property (
      ugWr && ctrlCopy_reg[1] |=> !updateEvent) else $error("update leaked");
   chk_trigger_irq: assert property (
      tgWr && ieCopy_reg[6] |=> irq) else $error("no trigger irq");
   chk_masked_quiet: assert property (
      ieCopy_reg == 8'h00 |-> !irq) else $error("irq while masked");
   chk_update_flag_irq: assert property (
      updateEvent && ieCopy_reg[0] && !ctrlCopy_reg[2] |-> irq)
      else $error("update without irq");
   chk_unmapped_error: assert property (
      acc && (paddr > ADDR_LAST || gapHole) |-> pslverr)
      else $error("no slave error");
   chk_mapped_no_error: assert property (
      acc && paddr <= ADDR_LAST && paddr[1:0] == 2'b00 && !gapHole
      |-> !pslverr)
      else $error("false slave error");
   cover property (ugWr ##1 updateEvent);
   cover property (irq ##1 !irq);
   cover property (acc && pslverr);
endmodule // basic_timer_properties

bind basic_timer basic_timer_properties #(.SYNCED(SYNCED),
   .COMPACT_LAYOUT(COMPACT_LAYOUT), .ADDR_W(ADDR_W)) chk_u (
   .clock(clock), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq),
   .updateEvent(updateEvent));

/* File: core/basic_timer.v */
// 8-bit auto-reload up timer with APB register slave
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`include "timer_map.vh"

// What this block does
// - writing one to trigger_generate sets trigger_flag; bit never holds
// - trigger interrupt reaches irq only when trigger_irq_enable is set
// - minimal variant: trigger_generate reserved, writes raise nothing
// - update_generate restarts counter and raises an update event
// - update_generate also clears the prescaler division counter
// - update_generate clears itself; writing zero does nothing
// - counter value is 8 bits, read/write, resets to zero
// - tick rate is clock divided by 2 to the 3-bit divider field
// - divider field copied to active setting on every update event
// - reload value is 8 bits, read/write, resets to all ones
// - minimal variant has compact or gapped layout, chosen by parameter
// - counts upward, ticks derive only from the master clock
// - update_disable blocks update events and keeps active copies
// - update events set update_flag, except software updates while update_source is set; only software clears it
// - one_shot_mode clears counter_run_enable at next update event
module basic_timer #(
   parameter SYNCED = 1,
   parameter COMPACT_LAYOUT = 0,
   parameter ADDR_W = 8,
   parameter DIV_W = 7
) (
   input wire clock,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output wire irq,
   output wire updateEvent
);

   // ****************************************************************
   // register storage
   // ****************************************************************
   reg [7:0] control_reg;
   reg [7:0] syncOut_reg;
   reg [7:0] syncIn_reg;
   reg [7:0] irqEnable_reg;
   reg [7:0] flags_reg;
   reg [7:0] count_reg;
   reg [7:0] count_next;
   reg [7:0] divSel_reg;
   reg [7:0] reloadPre_reg;
   reg [7:0] reloadAct_reg;
   reg [7:0] readData_reg;
   reg readErr_reg;
   reg update_reg;

   // ****************************************************************
   // address decode
   // ****************************************************************
   wire [3:0] rawIndex;
   wire upperZero;
   reg [3:0] logIndex;
   reg mapped;
   wire [7:0] eventMask;

   assign rawIndex = paddr[5:2];
   generate
      if (ADDR_W > 6) begin : gUpper
         assign upperZero = (paddr[ADDR_W-1:6] == {(ADDR_W-6){1'b0}});
      end else begin : gNoUpper
         assign upperZero = 1'b1;
      end
   endgenerate

   // event bits that exist in this variant
   assign eventMask = SYNCED ? `MASK_EVENTS_SYNCED : `MASK_EVENTS_MINIMAL;

   // map the bus index to the full-layout index
   always @* begin
      logIndex = rawIndex;
      if (!SYNCED && COMPACT_LAYOUT && rawIndex != `IDX_CONTROL_MAIN) begin
         logIndex = rawIndex + `IDX_COMPACT_SHIFT;
      end
      mapped = upperZero & (paddr[1:0] == 2'b00) &
               (logIndex <= `IDX_RELOAD_VALUE);
      if (!SYNCED && (logIndex == `IDX_SYNC_OUTPUT_SELECT ||
                      logIndex == `IDX_SYNC_INPUT_CONTROL)) begin
         mapped = 1'b0;
      end
      // high compact indices would wrap onto the control register
      if (!SYNCED && COMPACT_LAYOUT &&
          rawIndex > (`IDX_RELOAD_VALUE - `IDX_COMPACT_SHIFT)) begin
         mapped = 1'b0;
      end
   end

   // ****************************************************************
   // bus strobes
   // ****************************************************************
   wire setupPhase;
   wire writeStrobe;
   wire [7:0] wData;
   wire selControl;
   wire selSyncOut;
   wire selSyncIn;
   wire selIrqEn;
   wire selFlags;
   wire selRequest;
   wire selCount;
   wire selDivider;
   wire selReload;

   assign setupPhase = psel & ~penable;
   // writes take effect only at the completing access edge
   assign writeStrobe = psel & penable & pwrite & mapped;
   assign wData = pwdata[7:0];
   assign selControl = writeStrobe & (logIndex == `IDX_CONTROL_MAIN);
   assign selSyncOut = writeStrobe & (logIndex == `IDX_SYNC_OUTPUT_SELECT);
   assign selSyncIn = writeStrobe & (logIndex == `IDX_SYNC_INPUT_CONTROL);
   assign selIrqEn = writeStrobe & (logIndex == `IDX_IRQ_ENABLE);
   assign selFlags = writeStrobe & (logIndex == `IDX_EVENT_FLAGS);
   assign selRequest = writeStrobe & (logIndex == `IDX_EVENT_REQUEST);
   assign selCount = writeStrobe & (logIndex == `IDX_COUNT_VALUE);
   assign selDivider = writeStrobe & (logIndex == `IDX_DIVIDER_SELECT);
   assign selReload = writeStrobe & (logIndex == `IDX_RELOAD_VALUE);

   // zero wait states; error only for unmapped addresses
   assign pready = psel & penable;
   assign pslverr = psel & penable & readErr_reg;
   assign prdata = {24'h000000, readData_reg};

   // ****************************************************************
   // control field views
   // ****************************************************************
   wire runEnable;
   wire updateDisable;
   wire updateSource;
   wire oneShot;
   wire reloadBuffer;
   wire updateGenerate;
   wire triggerGenerate;

   assign runEnable = control_reg[`BIT_RUN_ENABLE];
   assign updateDisable = control_reg[`BIT_UPDATE_DISABLE];
   assign updateSource = control_reg[`BIT_UPDATE_SOURCE];
   assign oneShot = control_reg[`BIT_ONE_SHOT];
   assign reloadBuffer = control_reg[`BIT_RELOAD_BUFFER];
   // request bits act for one cycle only and never stay stored
   assign updateGenerate = selRequest & wData[`BIT_UPDATE];
   assign triggerGenerate = selRequest & wData[`BIT_TRIGGER] &
                            (SYNCED != 0);

   // ****************************************************************
   // counter tick and update event
   // ****************************************************************
   wire tick;
   wire overflow;
   wire updateNow;
   wire updFlagSet;

   // prescaler is fed from the master clock only
   timer_prescaler #(
      .DIV_W(DIV_W)
   ) uPrescaler (
      .clock(clock),
      .rst(rst),
      .run(runEnable),
      .clear(updateGenerate),
      .load(updateNow),
      .selectIn(divSel_reg[`DIV_FIELD_MSB:0]),
      .tick(tick)
   );

   assign overflow = tick & (count_reg == reloadAct_reg);
   // update_disable suppresses every update event
   assign updateNow = (overflow | updateGenerate) & ~updateDisable;
   // software updates raise the flag only with update_source clear
   assign updFlagSet = updateNow & (overflow | ~updateSource);
   assign updateEvent = update_reg;

   // counter next value, software write taking precedence
   always @* begin
      count_next = count_reg;
      if (selCount) begin
         count_next = wData;
      end else if (updateGenerate) begin
         count_next = `RST_ZERO;
      end else if (overflow) begin
         count_next = `RST_ZERO;
      end else if (tick) begin
         count_next = count_reg + 8'h01;
      end
   end

   // counter register
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         count_reg <= `RST_ZERO;
      end else begin
         count_reg <= count_next;
      end
   end

   // registered copy of the update event for the outside
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         update_reg <= 1'b0;
      end else begin
         update_reg <= updateNow;
      end
   end

   // ****************************************************************
   // control register with one-shot stop
   // ****************************************************************
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         control_reg <= `RST_ZERO;
      end else if (selControl) begin
         control_reg <= wData & `MASK_CONTROL_MAIN;
         if (updateNow && oneShot) begin
            control_reg[`BIT_RUN_ENABLE] <= 1'b0;
         end
      end else if (updateNow && oneShot) begin
         control_reg[`BIT_RUN_ENABLE] <= 1'b0;
      end
   end

   // ****************************************************************
   // synchronisation registers (stored only in the synced variant)
   // ****************************************************************
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         syncOut_reg <= `RST_ZERO;
         syncIn_reg <= `RST_ZERO;
      end else if (SYNCED != 0) begin
         if (selSyncOut) begin
            syncOut_reg <= wData & `MASK_SYNC_OUTPUT;
         end
         if (selSyncIn) begin
            syncIn_reg <= wData & `MASK_SYNC_INPUT;
         end
      end
   end

   // ****************************************************************
   // interrupt enable, divider and reload registers
   // ****************************************************************
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         irqEnable_reg <= `RST_ZERO;
         divSel_reg <= `RST_ZERO;
      end else begin
         if (selIrqEn) begin
            irqEnable_reg <= wData & eventMask;
         end
         if (selDivider) begin
            divSel_reg <= wData & `MASK_DIVIDER;
         end
      end
   end

   // reload preload and active copy; unbuffered writes go straight in
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         reloadPre_reg <= `RST_RELOAD;
         reloadAct_reg <= `RST_RELOAD;
      end else begin
         if (selReload) begin
            reloadPre_reg <= wData;
         end
         if (selReload && !reloadBuffer) begin
            reloadAct_reg <= wData;
         end else if (updateNow) begin
            reloadAct_reg <= reloadPre_reg;
         end
      end
   end

   // ****************************************************************
   // sticky event flags, write one to clear, set wins
   // ****************************************************************
   wire [7:0] flagSet;
   wire [7:0] flagClr;

   assign flagSet = ({7'h00, updFlagSet} << `BIT_UPDATE) |
                    ({7'h00, triggerGenerate} << `BIT_TRIGGER);
   assign flagClr = selFlags ? wData : 8'h00;

   genvar fi;
   generate
      for (fi = 0; fi < 8; fi = fi + 1) begin : gFlag
         // per-bit sticky flag
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               flags_reg[fi] <= 1'b0;
            end else if (!eventMask[fi]) begin
               flags_reg[fi] <= 1'b0;
            end else if (flagSet[fi]) begin
               flags_reg[fi] <= 1'b1;
            end else if (flagClr[fi]) begin
               flags_reg[fi] <= 1'b0;
            end
         end
      end
   endgenerate

   // level interrupt while any enabled flag is pending
   assign irq = |(flags_reg & irqEnable_reg);

   // ****************************************************************
   // read data, captured in the setup phase
   // ****************************************************************
   reg [7:0] readMux;

   // select read value by logical index
   always @* begin
      readMux = 8'h00;
      case (logIndex)
         `IDX_CONTROL_MAIN: readMux = control_reg;
         `IDX_SYNC_OUTPUT_SELECT: readMux = syncOut_reg;
         `IDX_SYNC_INPUT_CONTROL: readMux = syncIn_reg;
         `IDX_IRQ_ENABLE: readMux = irqEnable_reg;
         `IDX_EVENT_FLAGS: readMux = flags_reg;
         `IDX_EVENT_REQUEST: readMux = 8'h00;
         `IDX_COUNT_VALUE: readMux = count_reg;
         `IDX_DIVIDER_SELECT: readMux = divSel_reg;
         `IDX_RELOAD_VALUE: readMux = reloadPre_reg;
         default: readMux = 8'h00;
      endcase
      if (!mapped) begin
         readMux = 8'h00;
      end
   end

   // hold read data and error through the access phase
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         readData_reg <= 8'h00;
         readErr_reg <= 1'b0;
      end else if (setupPhase) begin
         readData_reg <= pwrite ? 8'h00 : readMux;
         readErr_reg <= ~mapped;
      end
   end

endmodule // basic_timer

/* File: core/timer_map.vh */
// register indices, field positions and reset values of the 8-bit timer
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_CONTROL_MAIN 4'h0
`define IDX_SYNC_OUTPUT_SELECT 4'h1
`define IDX_SYNC_INPUT_CONTROL 4'h2
`define IDX_IRQ_ENABLE 4'h3
`define IDX_EVENT_FLAGS 4'h4
`define IDX_EVENT_REQUEST 4'h5
`define IDX_COUNT_VALUE 4'h6
`define IDX_DIVIDER_SELECT 4'h7
`define IDX_RELOAD_VALUE 4'h8
// compact minimal layout moves irq enable and later down by this
`define IDX_COMPACT_SHIFT 4'h2

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_RUN_ENABLE 0
`define BIT_UPDATE_DISABLE 1
`define BIT_UPDATE_SOURCE 2
`define BIT_ONE_SHOT 3
`define BIT_RELOAD_BUFFER 7
`define BIT_UPDATE 0
`define BIT_TRIGGER 6
`define DIV_FIELD_MSB 2

// ****************************************************************
// writable bit masks (reserved bits read zero, ignore writes)
// ****************************************************************
`define MASK_CONTROL_MAIN 8'h8f
`define MASK_SYNC_OUTPUT 8'h70
`define MASK_SYNC_INPUT 8'hf7
`define MASK_EVENTS_SYNCED 8'h41
`define MASK_EVENTS_MINIMAL 8'h01
`define MASK_DIVIDER 8'h07

// ****************************************************************
// reset values
// ****************************************************************
`define RST_ZERO 8'h00
`define RST_RELOAD 8'hff

`endif

/* File: core/timer_prescaler.v */
// power-of-two prescaler with buffered division setting
`timescale 1ns/1ns
module timer_prescaler #(
   parameter DIV_W = 7
) (
   input wire clock,
   input wire rst,
   input wire run,
   input wire clear,
   input wire load,
   input wire [2:0] selectIn,
   output wire tick
);
   reg [DIV_W-1:0] divCount_reg;
   reg [2:0] activeSel_reg;
   wire [DIV_W-1:0] divMask;

   // terminal count is 2^setting - 1
   assign divMask = ~({DIV_W{1'b1}} << activeSel_reg);
   assign tick = run & ~clear & (divCount_reg == divMask);

   // active setting only changes on an update event
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         activeSel_reg <= 3'h0;
      end else if (load) begin
         activeSel_reg <= selectIn;
      end
   end

   // division counter, restarted by a forced update
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         divCount_reg <= {DIV_W{1'b0}};
      end else if (clear) begin
         divCount_reg <= {DIV_W{1'b0}};
      end else if (run) begin
         if (tick) begin
            divCount_reg <= {DIV_W{1'b0}};
         end else begin
            divCount_reg <= divCount_reg + {{(DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // timer_prescaler
